// File: verilog/agccs_pkg.sv
package agccs_pkg;

  // Register word indices; byte address is four times the index
  localparam int unsigned  AGCCS_AW            = 18;
  localparam logic [15:0]  AGCCS_IDX_LIMIT     = 16'hdf17;
  localparam logic [15:0]  AGCCS_IDX_PRIO      = 16'hdf18;
  localparam logic [15:0]  AGCCS_IDX_STATUS    = 16'hdf30;

  // Reset values
  localparam logic [7:0]   AGCCS_LIMIT_RST     = 8'h03;
  localparam logic [6:0]   AGCCS_PRIO_RST      = 7'h40;

  // Field positions
  localparam int unsigned  AGCCS_DG_LSB        = 6;
  localparam int unsigned  AGCCS_FA_LSB        = 3;
  localparam int unsigned  AGCCS_TGT_LSB       = 0;
  localparam int unsigned  AGCCS_ORDER_BIT     = 6;
  localparam int unsigned  AGCCS_REL_LSB       = 4;
  localparam int unsigned  AGCCS_ABS_LSB       = 0;

  // Codes and step counts
  localparam logic [3:0]   AGCCS_ABS_OFF       = 4'h8;
  localparam logic [1:0]   AGCCS_REL_OFF       = 2'h0;
  localparam logic [2:0]   AGCCS_TOP_STEP      = 3'h7;
  localparam logic [2:0]   AGCCS_AMP1_STEPS    = 3'h3;
  localparam logic [2:0]   AGCCS_AMP2_STEPS    = 3'h4;

  typedef enum logic [0:0] {
    AGCCS_IDLE  = 1'b0,
    AGCCS_TRACK = 1'b1
  } agccs_state_t;

  function automatic logic [7:0] agccs_target_db(input logic [2:0] code);
    case (code)
      3'h0:    agccs_target_db = 8'h18;
      3'h1:    agccs_target_db = 8'h1b;
      3'h2:    agccs_target_db = 8'h1e;
      3'h3:    agccs_target_db = 8'h21;
      3'h4:    agccs_target_db = 8'h24;
      3'h5:    agccs_target_db = 8'h26;
      3'h6:    agccs_target_db = 8'h28;
      default: agccs_target_db = 8'h2a;
    endcase
  endfunction

  function automatic logic [7:0] agccs_rel_db(input logic [1:0] code);
    case (code)
      2'h1:    agccs_rel_db = 8'h06;
      2'h2:    agccs_rel_db = 8'h0a;
      2'h3:    agccs_rel_db = 8'h0e;
      default: agccs_rel_db = 8'h00;
    endcase
  endfunction

endpackage

// File: verilog/agccs_amp_split.sv
`timescale 1ns/1ps
`default_nettype none
module agccs_amp_split
  import agccs_pkg::*;
(
  input  wire logic [2:0] fa_index_in,
  input  wire logic       order_in,
  output logic      [1:0] amp1_cut_out,
  output logic      [2:0] amp2_cut_out
);

  logic [2:0] cut;
  logic [2:0] c1;
  logic [2:0] c2;

  always_comb begin
    cut = AGCCS_TOP_STEP - fa_index_in;
    if (order_in) begin
      // First stage backs off first
      c1 = (cut > AGCCS_AMP1_STEPS) ? AGCCS_AMP1_STEPS : cut;
      c2 = cut - c1;
    end else begin
      // Second stage goes to minimum before the first moves
      c2 = (cut > AGCCS_AMP2_STEPS) ? AGCCS_AMP2_STEPS : cut;
      c1 = cut - c2;
    end
    amp1_cut_out = c1[1:0];
    amp2_cut_out = c2;
  end

endmodule
`default_nettype wire

// File: verilog/agccs_sense.sv
`timescale 1ns/1ps
`default_nettype none
module agccs_sense
  import agccs_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic       active_in,
  input  wire logic       amp_valid_in,
  input  wire logic [7:0] amp_in,
  input  wire logic [7:0] target_db_in,
  input  wire logic [3:0] abs_thr_in,
  input  wire logic [1:0] rel_code_in,
  output logic            sense_out
);

  typedef struct packed {
    logic       seen;
    logic [7:0] floor;
    logic       sense;
  } agccs_sense_s_t;

  agccs_sense_s_t s_q;
  agccs_sense_s_t s_d;
  logic signed [9:0] abs_level;
  logic        [9:0] rel_level;
  logic              abs_hit;
  logic              rel_hit;

  always_comb begin
    s_d = s_q;
    abs_level = $signed({2'b00, target_db_in}) + $signed({{6{abs_thr_in[3]}}, abs_thr_in});
    rel_level = {2'b00, s_q.floor} + {2'b00, agccs_rel_db(rel_code_in)};
    // Most negative code switches the absolute test off
    abs_hit = (abs_thr_in != AGCCS_ABS_OFF) &&
              ($signed({2'b00, amp_in}) >= abs_level);
    rel_hit = (rel_code_in != AGCCS_REL_OFF) && s_q.seen &&
              ({2'b00, amp_in} >= rel_level);
    if (!active_in) begin
      s_d.seen  = 1'b0;
      s_d.sense = 1'b0;
    end else if (amp_valid_in) begin
      // Floor tracks the quietest level seen since the receiver started
      if (!s_q.seen || amp_in < s_q.floor) begin
        s_d.floor = amp_in;
      end
      s_d.seen  = 1'b1;
      s_d.sense = abs_hit | rel_hit;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '{seen: 1'b0, floor: 8'h00, sense: 1'b0};
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign sense_out = s_q.sense;

endmodule
`default_nettype wire

// File: verilog/agccs_top.sv
`timescale 1ns/1ps
`default_nettype none
module agccs_top
  import agccs_pkg::*;
(
  input  wire logic                mclk_in,
  input  wire logic                rst_n_in,
  input  wire logic                ce_in,
  input  wire logic                wb_cyc_in,
  input  wire logic                wb_stb_in,
  input  wire logic                wb_we_in,
  input  wire logic [AGCCS_AW-1:0] wb_adr_in,
  input  wire logic [3:0]          wb_sel_in,
  input  wire logic [31:0]         wb_dat_in,
  output logic      [31:0]         wb_dat_out,
  output logic                     wb_ack_out,
  input  wire logic                rx_active_in,
  input  wire logic                amp_valid_in,
  input  wire logic [7:0]          amp_in,
  output logic      [2:0]          digital_gain_out,
  output logic      [1:0]          amp1_cut_out,
  output logic      [2:0]          second_front_amp_cut_out,
  output logic                     carrier_sense_out
);

  typedef struct packed {
    agccs_state_t st;
    logic [7:0]   limit;
    logic [6:0]   prio;
    logic         ack;
    logic [31:0]  rdat;
    logic [2:0]   dg;
    logic [2:0]   fa;
    logic [1:0]   cut1;
    logic [2:0]   cut2;
  } agccs_top_s_t;

  localparam agccs_top_s_t AGCCS_TOP_RST = '{
    st:    AGCCS_IDLE,
    limit: AGCCS_LIMIT_RST,
    prio:  AGCCS_PRIO_RST,
    ack:   1'b0,
    rdat:  32'h0000_0000,
    dg:    AGCCS_TOP_STEP,
    fa:    AGCCS_TOP_STEP,
    cut1:  2'h0,
    cut2:  3'h0
  };

  agccs_top_s_t s_q;
  agccs_top_s_t s_d;

  logic [15:0] idx;
  logic        req;
  logic [1:0]  dg_code;
  logic [2:0]  fa_code;
  logic [2:0]  tgt_code;
  logic        order;
  logic [1:0]  rel_code;
  logic [3:0]  abs_thr;
  logic [2:0]  dg_max;
  logic [2:0]  fa_max;
  logic [7:0]  target_db;
  logic [2:0]  dg_n;
  logic [2:0]  fa_n;
  logic [1:0]  split_cut1;
  logic [2:0]  split_cut2;
  logic        sense;

  // Fields are read straight from the live registers
  assign dg_code   = s_q.limit[AGCCS_DG_LSB +: 2];
  assign fa_code   = s_q.limit[AGCCS_FA_LSB +: 3];
  assign tgt_code  = s_q.limit[AGCCS_TGT_LSB +: 3];
  assign order     = s_q.prio[AGCCS_ORDER_BIT];
  assign rel_code  = s_q.prio[AGCCS_REL_LSB +: 2];
  assign abs_thr   = s_q.prio[AGCCS_ABS_LSB +: 4];
  assign target_db = agccs_target_db(tgt_code);
  assign dg_max    = AGCCS_TOP_STEP - {1'b0, dg_code};
  assign fa_max    = AGCCS_TOP_STEP - fa_code;

  assign idx = wb_adr_in[AGCCS_AW-1:2];
  assign req = wb_cyc_in & wb_stb_in & ~s_q.ack;

  agccs_amp_split u_split (
    .fa_index_in  (fa_n),
    .order_in     (order),
    .amp1_cut_out (split_cut1),
    .amp2_cut_out (split_cut2)
  );

  agccs_sense u_sense (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .ce_in        (ce_in),
    .active_in    (s_q.st == AGCCS_TRACK),
    .amp_valid_in (amp_valid_in),
    .amp_in       (amp_in),
    .target_db_in (target_db),
    .abs_thr_in   (abs_thr),
    .rel_code_in  (rel_code),
    .sense_out    (sense)
  );

  // Gain decision per amplitude sample: clamp to the ceilings, then at most one step
  always_comb begin
    dg_n = s_q.dg;
    fa_n = s_q.fa;
    case (s_q.st)
      AGCCS_IDLE: begin
        // Receiver off: park both amplifiers at their ceilings
        dg_n = dg_max;
        fa_n = fa_max;
      end
      AGCCS_TRACK: begin
        if (amp_valid_in) begin
          // A lowered ceiling pulls the gain down on the next amplitude sample
          if (dg_n > dg_max) begin
            dg_n = dg_max;
          end
          if (fa_n > fa_max) begin
            fa_n = fa_max;
          end
          // Strong signal: analog stages back off before digital
          if (amp_in > target_db) begin
            if (fa_n != 3'h0) begin
              fa_n = fa_n - 3'h1;
            end else if (dg_n != 3'h0) begin
              dg_n = dg_n - 3'h1;
            end
          end else if (amp_in < target_db) begin
            // Weak signal: digital gain rises first to keep noise low
            if (dg_n < dg_max) begin
              dg_n = dg_n + 3'h1;
            end else if (fa_n < fa_max) begin
              fa_n = fa_n + 3'h1;
            end
          end
        end
      end
      default: begin
        dg_n = dg_max;
        fa_n = fa_max;
      end
    endcase
  end

  always_comb begin
    s_d      = s_q;
    s_d.dg   = dg_n;
    s_d.fa   = fa_n;
    s_d.cut1 = split_cut1;
    s_d.cut2 = split_cut2;
    s_d.st   = rx_active_in ? AGCCS_TRACK : AGCCS_IDLE;
    s_d.ack  = req;
    if (req) begin
      s_d.rdat = 32'h0000_0000;
      case (idx)
        AGCCS_IDX_LIMIT: begin
          s_d.rdat[7:0] = s_q.limit;
          if (wb_we_in && wb_sel_in[0]) begin
            s_d.limit = wb_dat_in[7:0];
          end
        end
        AGCCS_IDX_PRIO: begin
          // Bit 7 is unused and reads zero
          s_d.rdat[6:0] = s_q.prio;
          if (wb_we_in && wb_sel_in[0]) begin
            s_d.prio = wb_dat_in[6:0];
          end
        end
        AGCCS_IDX_STATUS: begin
          s_d.rdat[7:0] = {sense, s_q.st == AGCCS_TRACK, s_q.fa, s_q.dg};
        end
        default: begin
          s_d.rdat = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= AGCCS_TOP_RST;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign wb_ack_out               = s_q.ack;
  assign wb_dat_out               = s_q.rdat;
  assign digital_gain_out         = s_q.dg;
  assign amp1_cut_out             = s_q.cut1;
  assign second_front_amp_cut_out = s_q.cut2;
  assign carrier_sense_out        = sense;

endmodule
`default_nettype wire

// File: verif/agccs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module agccs_checker
  import agccs_pkg::*;
(
  input wire logic                mclk_in,
  input wire logic                rst_n_in,
  input wire logic                ce_in,
  input wire logic                wb_cyc_in,
  input wire logic                wb_stb_in,
  input wire logic                wb_we_in,
  input wire logic [AGCCS_AW-1:0] wb_adr_in,
  input wire logic [3:0]          wb_sel_in,
  input wire logic [31:0]         wb_dat_in,
  input wire logic [31:0]         wb_dat_out,
  input wire logic                wb_ack_out,
  input wire logic                rx_active_in,
  input wire logic                amp_valid_in,
  input wire logic [7:0]          amp_in,
  input wire logic [2:0]          digital_gain_out,
  input wire logic [1:0]          amp1_cut_out,
  input wire logic [2:0]          second_front_amp_cut_out,
  input wire logic                carrier_sense_out
);
  logic [7:0] lim_q;
  // Shadow of the limit register, so parked gains can be judged
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lim_q <= 8'h03;
    end else if (ce_in && wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in && wb_sel_in[0]
                 && wb_adr_in[17:2] == AGCCS_IDX_LIMIT) begin
      lim_q <= wb_dat_in[7:0];
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_req;
    ce_in && wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  // Bus kept quiet so a ceiling write cannot race the check
  sequence s_parked;
    (ce_in && !rx_active_in && !wb_stb_in) [*3];
  endsequence
  property p_ack_next;
    s_req |=> wb_ack_out;
  endproperty
  property p_ack_pulse;
    wb_ack_out && ce_in |=> !wb_ack_out;
  endproperty
  property p_rd_lim;
    s_req ##0 (!wb_we_in && wb_adr_in[17:2] == AGCCS_IDX_LIMIT) |=> wb_dat_out == {24'h0, lim_q};
  endproperty
  property p_dg_park;
    s_parked |=> digital_gain_out == 3'h7 - {1'b0, lim_q[7:6]};
  endproperty
  property p_fa_park;
    s_parked |=> {1'b0, amp1_cut_out} + second_front_amp_cut_out == lim_q[5:3];
  endproperty
  property p_cs_clear;
    s_parked |=> !carrier_sense_out;
  endproperty
  property p_cs_rise;
    $rose(carrier_sense_out) |-> $past(amp_valid_in);
  endproperty
  property p_dg_hold;
    (ce_in && rx_active_in) [*2] ##0 (ce_in && !amp_valid_in) |=> $stable(digital_gain_out);
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_rd_lim: assert property (p_rd_lim) else $error("limit readback wrong");
  a_dg_park: assert property (p_dg_park) else $error("digital ceiling wrong");
  a_fa_park: assert property (p_fa_park) else $error("front ceiling wrong");
  a_cs_clear: assert property (p_cs_clear) else $error("sense not cleared");
  a_cs_rise: assert property (p_cs_rise) else $error("sense rose unprompted");
  a_dg_hold: assert property (p_dg_hold) else $error("gain moved unprompted");
endmodule
bind agccs_top agccs_checker u_chk (.*);
`default_nettype wire

// File: verif/agccs_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module agccs_top_tb_top
  import agccs_pkg::*;
;
  logic        mclk_in = 1'b0;
  logic        rst_n_in, ce_in, wb_cyc_in, wb_stb_in, wb_we_in;
  logic [3:0]  sel_req;
  logic        rx_active_in, amp_valid_in, wb_ack_out, carrier_sense_out;
  logic [17:0] wb_adr_in;
  logic [3:0]  wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out, rd;
  logic [7:0]  amp_in;
  logic [2:0]  digital_gain_out, second_front_amp_cut_out;
  logic [1:0]  amp1_cut_out;
  logic [23:0] rows [5];
  int          tg [8];
  int          off [3];
  int          dd [4];
  int          err_count, checked;
  agccs_top dut (.*);
  always #5 mclk_in = ~mclk_in;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [15:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk_in);
    {wb_cyc_in, wb_stb_in, wb_we_in} <= {2'b11, we};
    wb_sel_in <= sel_req;
    wb_adr_in <= {idx, 2'b00};
    wb_dat_in <= {24'h0, d};
    do begin
      @(posedge mclk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk({31'h0, wb_ack_out}, 32'h1);
    end
    rd = wb_dat_out;
    {wb_cyc_in, wb_stb_in} <= 2'b00;
  endtask
  task automatic smp(input logic [7:0] a, input logic exp);
    @(posedge mclk_in);
    amp_valid_in <= 1'b1;
    amp_in <= a;
    @(posedge mclk_in);
    amp_valid_in <= 1'b0;
    #1;
    chk(carrier_sense_out, exp);
  endtask
  task automatic park(input logic [7:0] lim, input logic [7:0] prio);
    @(posedge mclk_in);
    rx_active_in <= 1'b0;
    bus(1'b1, AGCCS_IDX_LIMIT, lim);
    bus(1'b1, AGCCS_IDX_PRIO, prio);
    repeat (4) @(posedge mclk_in);
  endtask
  task automatic track();
    @(posedge mclk_in);
    rx_active_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    summarize();
  end
  initial begin
    {rst_n_in, wb_cyc_in, wb_stb_in, wb_we_in, rx_active_in, amp_valid_in} = '0;
    ce_in = 1'b1;
    wb_sel_in = 4'h1;
    sel_req = 4'h1;
    wb_adr_in = '0;
    wb_dat_in = '0;
    amp_in = '0;
    err_count = 0;
    checked = 0;
    rows = '{24'h0040e0, 24'h4840c8, 24'ha000a4, 24'he04099, 24'h3800fc};
    tg = '{24, 27, 30, 33, 36, 38, 40, 42};
    off = '{-7, -1, 7};
    dd = '{0, 6, 10, 14};
    repeat (6) @(posedge mclk_in);
    chk({digital_gain_out, amp1_cut_out, second_front_amp_cut_out, carrier_sense_out, wb_ack_out}, 32'h380);
    rst_n_in <= 1'b1;
    bus(1'b0, AGCCS_IDX_LIMIT, 8'h00);
    chk(rd, 32'h03);
    bus(1'b0, AGCCS_IDX_PRIO, 8'h00);
    chk(rd, 32'h40);
    bus(1'b0, 16'h0001, 8'h00);
    chk(rd, 32'h0);
    bus(1'b1, AGCCS_IDX_PRIO, 8'hff);
    bus(1'b0, AGCCS_IDX_PRIO, 8'h00);
    chk(rd, 32'h7f);
    $display("register test done");
    for (int i = 0; i < 5; i++) begin
      park(rows[i][23:16], rows[i][15:8]);
      #1;
      chk({digital_gain_out, amp1_cut_out, second_front_amp_cut_out}, rows[i][7:0]);
    end
    $display("ceiling table done");
    park(8'h03, 8'h40);
    track();
    smp(8'h28, 1'b1);
    chk({digital_gain_out, amp1_cut_out, second_front_amp_cut_out}, 32'he8);
    smp(8'h20, 1'b0);
    chk({digital_gain_out, amp1_cut_out, second_front_amp_cut_out}, 32'he0);
    // Target changes land on the very next sample, no commit write
    for (int t = 0; t < 8; t++) begin
      bus(1'b1, AGCCS_IDX_LIMIT, 8'(t));
      smp(8'(tg[t]), 1'b1);
      smp(8'(tg[t] - 1), 1'b0);
    end
    bus(1'b1, AGCCS_IDX_LIMIT, 8'h03);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, AGCCS_IDX_PRIO, {4'h4, 4'(off[i])});
      smp(8'(33 + off[i]), 1'b1);
      smp(8'(32 + off[i]), 1'b0);
    end
    bus(1'b1, AGCCS_IDX_PRIO, 8'h48);
    smp(8'hff, 1'b0);
    $display("absolute test done");
    // The second sample sits just under the floor plus step, so only the third may trip
    for (int c = 0; c < 4; c++) begin
      park(8'h03, {2'b01, 2'(c), 4'h8});
      track();
      smp(8'd20, 1'b0);
      smp(8'(19 + dd[c]), 1'b0);
      smp(8'(20 + dd[c]), c != 0);
    end
    $display("relative test done");
    // Status holds sense, tracking flag, front index and digital gain
    bus(1'b0, AGCCS_IDX_STATUS, 8'h00);
    chk(rd, 32'hf7);
    // A frozen clock enable must ignore a sample that would drop sense and raise gain
    @(posedge mclk_in);
    ce_in <= 1'b0;
    smp(8'h00, 1'b1);
    chk({digital_gain_out, amp1_cut_out, second_front_amp_cut_out}, 32'he8);
    @(posedge mclk_in);
    ce_in <= 1'b1;
    // A write with its byte lane off must leave the register alone
    sel_req = 4'h0;
    bus(1'b1, AGCCS_IDX_LIMIT, 8'hff);
    sel_req = 4'h1;
    bus(1'b0, AGCCS_IDX_LIMIT, 8'h00);
    chk(rd, 32'h03);
    // A lowered digital ceiling clamps the running gain on the next sample
    bus(1'b1, AGCCS_IDX_LIMIT, 8'hc1);
    smp(8'd27, 1'b0);
    chk({digital_gain_out, amp1_cut_out, second_front_amp_cut_out}, 32'h88);
    // Reset in mid-run while tracking
    @(posedge mclk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    chk({digital_gain_out, amp1_cut_out, second_front_amp_cut_out, carrier_sense_out, wb_ack_out}, 32'h380);
    rst_n_in <= 1'b1;
    bus(1'b0, AGCCS_IDX_LIMIT, 8'h00);
    chk(rd, 32'h03);
    $display("awkward cases done");
    summarize();
  end
endmodule
`default_nettype wire
